// *** pkg/eau_pkg.sv ***
package eau_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_LOC    = 8'h08;
	localparam logic [7:0] REG_FLAGS  = 8'h0c;
	localparam logic [7:0] REG_ACC    = 8'h10;
	localparam logic [7:0] REG_SAVE   = 8'h14;
	localparam logic [7:0] REG_EA     = 8'h18;
	localparam logic [7:0] REG_XBASE  = 8'h20;
	localparam logic [7:0] REG_XLAST  = 8'h3c;

	// ----------------------------------------------------------------
	// Field positions (bit 0 of the word is our bit 31)
	// ----------------------------------------------------------------
	localparam int F_ADDR_HI = 31;
	localparam int F_ADDR_LO = 16;
	localparam int F_IND     = 15;
	localparam int F_X_HI    = 14;
	localparam int F_X_LO    = 12;
	localparam int F_REPL_LO = 12;
	localparam int F_OP_HI   = 11;
	localparam int F_OP_LO   = 8;
	localparam int F_SAVE    = 7;
	localparam int F_MODE_HI = 6;
	localparam int F_MODE_LO = 5;
	localparam int F_CLS_HI  = 3;
	localparam int F_CLS_LO  = 1;
	localparam int F_RND     = 14;

	// Flag bits and control bits
	localparam int FLG_Z = 0;
	localparam int FLG_G = 1;
	localparam int FLG_L = 2;
	localparam int FLG_C = 3;
	localparam int FLG_V = 4;
	localparam int CTL_RUN = 0;
	localparam int CTL_ABCLR = 1;

	// Reset values and the trap number
	localparam logic [15:0] LOC_RST   = 16'h0000;
	localparam logic [4:0]  FLAGS_RST = 5'h00;
	localparam logic [7:0]  TRAP_NUM  = 8'h02;

	// Half-word modes, operations, classes
	localparam logic [1:0] MODE_LEFT = 2'h0;
	localparam logic [1:0] MODE_RIGHT = 2'h1;
	localparam logic [1:0] MODE_IMM  = 2'h2;
	localparam logic [3:0] OP_SB = 4'h0, OP_CS = 4'h1, OP_CA = 4'h2, OP_AD = 4'h3, OP_CP = 4'h4;
	localparam logic [3:0] OP_MP = 4'h5, OP_ST = 4'h6, OP_SR = 4'h7, OP_DV = 4'h8, OP_CD = 4'h9;
	localparam logic [2:0] CLS_FIX = 3'h0, CLS_EXT = 3'h1, CLS_FLT = 3'h2;
	localparam logic [2:0] CLS_DBL = 3'h3, CLS_INT = 3'h4, CLS_IDX = 3'h5;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_FETCH   = 3'b001,
		ST_RESOLVE = 3'b010,
		ST_INDIR   = 3'b011,
		ST_DECIDE  = 3'b100,
		ST_OPER    = 3'b101,
		ST_EXEC    = 3'b110
	} eau_state_t;
endpackage : eau_pkg

// *** design/eau_xregs.sv ***
// Seven index registers; number one doubles as the accumulator
module eau_xregs
	import eau_pkg::*;
#(
	parameter int XW = 16
) (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// Write port
	input  wire logic          we,
	input  wire logic [2:0]    wsel,
	input  wire logic [XW-1:0] wdata,
	// Read ports
	input  wire logic [2:0]    rsel_a,
	output logic      [XW-1:0] rdata_a,
	input  wire logic [2:0]    rsel_b,
	output logic      [XW-1:0] rdata_b,
	output logic      [XW-1:0] acc
);
	// Elaboration guard: the address adder is fixed at 16 bits
	if (XW != 16) begin : g_xw_chk
		$error("eau_xregs: only 16-bit index registers");
	end

	logic [XW-1:0] x_reg [1:7];

	// One register per select code; code zero holds nothing
	for (genvar i = 1; i <= 7; i++) begin : g_x
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				x_reg[i] <= '0;
			end else if (we && wsel == 3'(i)) begin
				x_reg[i] <= wdata;
			end
		end
	end

	// Select zero reads zero, so callers may add it blindly
	assign rdata_a = (rsel_a == 3'h0) ? '0 : x_reg[rsel_a];
	assign rdata_b = (rsel_b == 3'h0) ? '0 : x_reg[rsel_b];
	assign acc     = x_reg[1];
endmodule : eau_xregs

// *** design/eau_alu.sv ***
// 16-bit fixed-point execution with flag sources
module eau_alu
	import eau_pkg::*;
(
	// Decoded instruction
	input  wire logic [3:0]  op,
	input  wire logic [2:0]  cls,
	// Operands
	input  wire logic [15:0] acc,
	input  wire logic [15:0] ext,
	input  wire logic [15:0] opd,
	// Results
	output logic      [15:0] res_acc,
	output logic      [15:0] res_ext,
	output logic      [15:0] flag_val,
	output logic             acc_we,
	output logic             ext_we,
	output logic             c_upd,
	output logic             carry,
	output logic             ovf,
	output logic             trap
);
	logic [16:0] sum;
	logic [16:0] dif;
	logic [16:0] rnd;
	logic [31:0] prod;
	logic [31:0] dvd;
	logic [31:0] dvs;
	logic [31:0] quo;
	logic [31:0] rem;
	logic        qbad;

	// Shared arithmetic; divide by zero is caught before use
	assign sum  = {1'b0, acc} + {1'b0, opd};
	assign dif  = {1'b0, acc} - {1'b0, opd};
	assign rnd  = {1'b0, acc} + {16'h0000, ext[F_RND]};
	assign prod = 32'($signed(acc) * $signed(opd));
	assign dvd  = (op == OP_CD) ? {acc, 16'h0000} : {acc, ext};
	assign dvs  = {{16{opd[15]}}, opd};
	assign quo  = (opd == 16'h0000) ? 32'h0 : 32'($signed(dvd) / $signed(dvs));
	assign rem  = (opd == 16'h0000) ? 32'h0 : 32'($signed(dvd) % $signed(dvs));
	assign qbad = (opd == 16'h0000) || (quo[31:15] != {17{quo[15]}});

	// Ops needing double-length registers go to software
	assign trap = (cls == CLS_EXT || cls == CLS_DBL) &&
		(op == OP_MP || op == OP_DV || op == OP_CD || op == OP_CP || op == OP_SR);

	// Result and flag sources per operation
	always_comb begin
		res_acc  = acc;
		res_ext  = ext;
		flag_val = acc;
		acc_we   = 1'b0;
		ext_we   = 1'b0;
		c_upd    = 1'b0;
		carry    = 1'b0;
		ovf      = 1'b0;
		case (op)
			OP_SB: begin res_acc = dif[15:0]; acc_we = 1'b1; c_upd = 1'b1; carry = dif[16]; end
			OP_CS: begin res_acc = 16'(-opd); acc_we = 1'b1; end
			OP_CA: begin res_acc = opd; acc_we = 1'b1; end
			OP_AD: begin res_acc = sum[15:0]; acc_we = 1'b1; c_upd = 1'b1; carry = sum[16]; end
			OP_CP: flag_val = dif[15:0];
			OP_MP: begin
				res_acc = prod[31:16];
				res_ext = {1'b0, prod[14:0]};
				acc_we  = 1'b1;
				ext_we  = 1'b1;
			end
			OP_ST: flag_val = acc;
			OP_SR: begin flag_val = rnd[15:0]; c_upd = 1'b1; carry = rnd[16]; end
			OP_DV, OP_CD: begin
				ovf     = qbad;
				res_acc = quo[15:0];
				res_ext = rem[15:0];
				acc_we  = !qbad;
				ext_we  = !qbad;
			end
			default: flag_val = acc;
		endcase
		if (acc_we) flag_val = res_acc;
	end
endmodule : eau_alu

// *** design/eau_top.sv ***
// Added by the designer: the AXI4-Lite slave port and the register offsets.
module eau_top
	import eau_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite register slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Core memory read port
	output logic             mem_req,
	output logic [15:0]      mem_addr,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	// Pins: interrupt and manual halt
	input  wire logic        irq_pin,
	input  wire logic        halt_pin,
	// Trap and state
	output logic             trap_pulse,
	output logic [7:0]       trap_num,
	output logic             busy
);
	// ----------------------------------------------------------------
	// Registers and wires
	// ----------------------------------------------------------------
	eau_state_t  state_reg;
	logic [31:0] instr_reg;
	logic [15:0] loc_reg;
	logic [15:0] ea_reg;
	logic [15:0] opd_reg;
	logic [15:0] ext_reg;
	logic [15:0] save_reg;
	logic [4:0]  flags_reg;
	logic        run_reg;
	logic        abort_reg;
	logic [1:0]  irq_sync;
	logic [1:0]  halt_sync;
	logic        abort;
	logic [2:0]  x_sel;
	logic        use_x;
	logic [15:0] xval;
	logic [15:0] xrd;
	logic [15:0] acc;
	logic [15:0] eff;
	logic [3:0]  op;
	logic [2:0]  cls;
	logic [1:0]  mode;
	logic        is16;
	logic        imm_ok;
	logic [15:0] res_acc;
	logic [15:0] res_ext;
	logic [15:0] flag_val;
	logic        acc_we;
	logic        ext_we;
	logic        c_upd;
	logic        carry;
	logic        ovf;
	logic        trap;
	logic        exec_ok;
	logic        x_we;
	logic [2:0]  x_wsel;
	logic [15:0] x_wdata;
	logic        aw_full;
	logic        w_full;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_go;
	logic [15:0] xcur;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_sync  <= 2'b00;
			halt_sync <= 2'b00;
		end else begin
			irq_sync  <= {irq_sync[0], irq_pin};
			halt_sync <= {halt_sync[0], halt_pin};
		end
	end
	assign abort = irq_sync[1] || halt_sync[1];

	// ----------------------------------------------------------------
	// Instruction decode
	// ----------------------------------------------------------------
	assign op     = instr_reg[F_OP_HI:F_OP_LO];
	assign cls    = instr_reg[F_CLS_HI:F_CLS_LO];
	assign mode   = instr_reg[F_MODE_HI:F_MODE_LO];
	assign x_sel  = instr_reg[F_X_HI:F_X_LO];
	assign use_x  = (x_sel != 3'h0) && (cls != CLS_IDX);
	assign xval   = use_x ? xrd : 16'h0000;
	// Wrapping 16-bit add is the two's complement sum
	assign eff    = instr_reg[F_ADDR_HI:F_ADDR_LO] + xval;
	assign is16   = (cls == CLS_FIX) || (cls == CLS_INT) || (cls == CLS_IDX);
	// Immediate never on store or store-rounded
	assign imm_ok = (mode == MODE_IMM) && is16 && (op != OP_ST) && (op != OP_SR);
	assign exec_ok = (state_reg == ST_EXEC) && !trap;
	assign busy   = (state_reg != ST_IDLE);

	eau_xregs #(.XW(16)) u_xregs (
		.aclk    (aclk),
		.aresetn (aresetn),
		.we      (x_we),
		.wsel    (x_wsel),
		.wdata   (x_wdata),
		.rsel_a  (x_sel),
		.rdata_a (xrd),
		.rsel_b  (wr_addr[4:2]),
		.rdata_b (xcur),
		.acc     (acc)
	);

	eau_alu u_alu (
		.op       (op),
		.cls      (cls),
		.acc      (acc),
		.ext      (ext_reg),
		.opd      (opd_reg),
		.res_acc  (res_acc),
		.res_ext  (res_ext),
		.flag_val (flag_val),
		.acc_we   (acc_we),
		.ext_we   (ext_we),
		.c_upd    (c_upd),
		.carry    (carry),
		.ovf      (ovf),
		.trap     (trap)
	);

	// ----------------------------------------------------------------
	// Address resolution and instruction sequencer
	// ----------------------------------------------------------------
	// Request is dropped on abort; a late acknowledge is then ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			instr_reg <= 32'h0;
			ea_reg    <= 16'h0;
			opd_reg   <= 16'h0;
			mem_req   <= 1'b0;
			mem_addr  <= 16'h0;
		end else begin
			case (state_reg)
				ST_IDLE: if (run_reg && !halt_sync[1]) begin
					state_reg <= ST_FETCH;
					mem_req   <= 1'b1;
					mem_addr  <= loc_reg;
				end
				ST_FETCH: if (mem_ack) begin
					instr_reg <= mem_rdata;
					mem_req   <= 1'b0;
					state_reg <= ST_RESOLVE;
				end
				ST_RESOLVE: if (abort) begin
					state_reg <= ST_IDLE;
				end else begin
					ea_reg <= eff;
					if (instr_reg[F_IND]) begin
						state_reg <= ST_INDIR;
						mem_req   <= 1'b1;
						mem_addr  <= eff;
					end else begin
						state_reg <= ST_DECIDE;
					end
				end
				ST_INDIR: if (abort) begin
					mem_req   <= 1'b0;
					state_reg <= ST_IDLE;
				end else if (mem_ack) begin
					instr_reg[F_ADDR_HI:F_REPL_LO] <= mem_rdata[F_ADDR_HI:F_REPL_LO];
					mem_req   <= 1'b0;
					state_reg <= ST_RESOLVE;
				end
				ST_DECIDE: if (imm_ok) begin
					opd_reg   <= ea_reg;
					state_reg <= ST_EXEC;
				end else begin
					state_reg <= ST_OPER;
					mem_req   <= 1'b1;
					mem_addr  <= ea_reg;
				end
				ST_OPER: if (mem_ack) begin
					// Right half only on request; else left
					opd_reg   <= (is16 && mode == MODE_RIGHT) ? mem_rdata[15:0] : mem_rdata[31:16];
					mem_req   <= 1'b0;
					state_reg <= ST_EXEC;
				end
				ST_EXEC: state_reg <= ST_IDLE;
				default: begin
					state_reg <= ST_IDLE;
					mem_req   <= 1'b0;
				end
			endcase
		end
	end

	// Save copy taken on both paths right after the immediate test
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			save_reg <= 16'h0;
		end else if (state_reg == ST_DECIDE && instr_reg[F_SAVE]) begin
			save_reg <= acc;
		end
	end

	// Location counter: advances per instruction, software loads when idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loc_reg <= LOC_RST;
		end else if (state_reg == ST_EXEC) begin
			loc_reg <= loc_reg + 16'h1;
		end else if (wr_go && wr_addr == REG_LOC && state_reg == ST_IDLE) begin
			loc_reg <= strb16(loc_reg, wr_data[15:0], wr_strb[1:0]);
		end
	end

	// Accumulator extension and trap output
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_reg    <= 16'h0;
			trap_pulse <= 1'b0;
			trap_num   <= 8'h0;
		end else begin
			if (exec_ok && ext_we) ext_reg <= res_ext;
			trap_pulse <= (state_reg == ST_EXEC) && trap;
			if ((state_reg == ST_EXEC) && trap) trap_num <= TRAP_NUM;
		end
	end

	// Flags: hardware set wins over a software clear of C or V
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_reg <= FLAGS_RST;
		end else begin
			if (wr_go && wr_addr == REG_FLAGS && wr_strb[0]) begin
				flags_reg[FLG_C] <= flags_reg[FLG_C] & ~wr_data[FLG_C];
				flags_reg[FLG_V] <= flags_reg[FLG_V] & ~wr_data[FLG_V];
			end
			if (exec_ok) begin
				flags_reg[FLG_Z] <= (flag_val == 16'h0000);
				flags_reg[FLG_G] <= !flag_val[15] && (flag_val != 16'h0000);
				flags_reg[FLG_L] <= flag_val[15];
				if (c_upd && carry) flags_reg[FLG_C] <= 1'b1;
				if (ovf) flags_reg[FLG_V] <= 1'b1;
			end
		end
	end

	// Index write: execution beats a simultaneous bus write
	assign x_we    = (exec_ok && acc_we) || (wr_go && x_hit(wr_addr));
	assign x_wsel  = (exec_ok && acc_we) ? 3'h1 : wr_addr[4:2];
	assign x_wdata = (exec_ok && acc_we) ? res_acc : strb16(xcur, wr_data[15:0], wr_strb[1:0]);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// Index register select addresses; writes load them, reads answer OKAY with zero
	function automatic logic x_hit(input logic [7:0] a);
		x_hit = (a > REG_XBASE) && (a <= REG_XLAST) && (a[1:0] == 2'b00);
	endfunction : x_hit

	function automatic logic mapped(input logic [7:0] a);
		mapped = x_hit(a) || a == REG_CTRL || a == REG_STATUS || a == REG_LOC ||
			a == REG_FLAGS || a == REG_ACC || a == REG_SAVE || a == REG_EA;
	endfunction : mapped

	function automatic logic [15:0] strb16(input logic [15:0] o, input logic [15:0] n,
		input logic [1:0] s);
		strb16 = {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
	endfunction : strb16

	assign s_axi_awready = !aw_full;
	assign s_axi_wready  = !w_full;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_full && w_full && !s_axi_bvalid && mapped(wr_addr);

	// Address and data taken in either order, held until both are here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full      <= 1'b0;
			w_full       <= 1'b0;
			wr_addr      <= 8'h0;
			wr_data      <= 32'h0;
			wr_strb      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_full) begin
				aw_full <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full) begin
				w_full  <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (aw_full && w_full && !s_axi_bvalid) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Run and abort status; halt pin wins over a run write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_reg   <= 1'b0;
			abort_reg <= 1'b0;
		end else begin
			if (wr_go && wr_addr == REG_CTRL && wr_strb[0]) begin
				run_reg <= wr_data[CTL_RUN];
				if (wr_data[CTL_ABCLR]) abort_reg <= 1'b0;
			end
			if (halt_sync[1]) run_reg <= 1'b0;
			if ((state_reg == ST_RESOLVE || state_reg == ST_INDIR) && abort) abort_reg <= 1'b1;
		end
	end

	// Read answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				REG_CTRL:   s_axi_rdata <= {31'h0, run_reg};
				REG_STATUS: s_axi_rdata <= {27'h0, abort_reg, 1'b0, state_reg};
				REG_LOC:    s_axi_rdata <= {16'h0, loc_reg};
				REG_FLAGS:  s_axi_rdata <= {27'h0, flags_reg};
				REG_ACC:    s_axi_rdata <= {ext_reg, acc};
				REG_SAVE:   s_axi_rdata <= {16'h0, save_reg};
				REG_EA:     s_axi_rdata <= {16'h0, ea_reg};
				default:    s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_resolve_go;
		state_reg == ST_RESOLVE && !abort;
	endsequence
	sequence s_indir_ack;
		state_reg == ST_INDIR && !abort && mem_ack;
	endsequence

	property p_fetch_addr;
		state_reg == ST_IDLE && run_reg && !halt_sync[1] |=> mem_req && mem_addr == $past(loc_reg);
	endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("fetch not at location counter");

	property p_index_sum;
		s_resolve_go |=> ea_reg == 16'($past(instr_reg[F_ADDR_HI:F_ADDR_LO]) + $past(xval));
	endproperty
	a_index_sum: assert property (p_index_sum) else $error("effective address sum wrong");

	property p_no_index;
		s_resolve_go ##0 (x_sel == 3'h0 || cls == CLS_IDX) |=>
			ea_reg == $past(instr_reg[F_ADDR_HI:F_ADDR_LO]);
	endproperty
	a_no_index: assert property (p_no_index) else $error("index applied when not allowed");

	property p_indir_load;
		s_indir_ack |=> instr_reg[F_ADDR_HI:F_REPL_LO] == $past(mem_rdata[F_ADDR_HI:F_REPL_LO])
			&& $stable(instr_reg[F_OP_HI:0]) ##1 state_reg == ST_DECIDE || state_reg == ST_INDIR
			|| state_reg == ST_IDLE;
	endproperty
	a_indir_load: assert property (p_indir_load) else $error("indirect word not merged");

	property p_abort;
		(state_reg == ST_RESOLVE || state_reg == ST_INDIR) && abort |=> state_reg == ST_IDLE && !mem_req;
	endproperty
	a_abort: assert property (p_abort) else $error("resolution not aborted");

	property p_immediate;
		state_reg == ST_DECIDE && imm_ok |=> opd_reg == $past(ea_reg) && !mem_req;
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate operand wrong");

	property p_save;
		state_reg == ST_DECIDE && instr_reg[F_SAVE] |=> save_reg == $past(acc);
	endproperty
	a_save: assert property (p_save) else $error("save copy missed");

	property p_trap;
		state_reg == ST_EXEC && trap |=> trap_pulse && trap_num == TRAP_NUM && $stable(acc) ##1 !trap_pulse;
	endproperty
	a_trap: assert property (p_trap) else $error("trap two not raised");

	property p_acc_kept;
		state_reg == ST_EXEC && (op == OP_CP || op == OP_ST || op == OP_SR) |=> $stable(acc);
	endproperty
	a_acc_kept: assert property (p_acc_kept) else $error("accumulator changed");

	property p_wait_ack;
		(state_reg == ST_FETCH || state_reg == ST_OPER) && !mem_ack |=> $stable(state_reg) && mem_req;
	endproperty
	a_wait_ack: assert property (p_wait_ack) else $error("moved on without acknowledge");
endmodule : eau_top

// *** testbench/eau_mem_model.sv ***
// Core memory bank answering reads after a random delay
module eau_mem_model
	import eau_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Read port
	input  wire logic        mem_req,
	input  wire logic [15:0] mem_addr,
	output logic             mem_ack,
	output logic      [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] m [0:255];
	int          wait_n = 0;
	initial {mem_ack, mem_rdata} = '0;
	// Data toggles outside an answer, so a stale word is never mistaken for a fresh one
	always @(posedge aclk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (aresetn && mem_req && !mem_ack) begin
			if (wait_n == 0) begin
				mem_ack <= 1'b1;
				mem_rdata <= m[mem_addr[7:0]];
				wait_n <= $urandom % 4;
			end else begin
				wait_n <= wait_n - 1;
			end
		end
	end
endmodule : eau_mem_model

// *** testbench/tb_effective_address_unit.sv ***
module tb_effective_address_unit
	import eau_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 0, aresetn = 0, irq_pin = 0, halt_pin = 0;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, trap_num;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, mem_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [15:0] mem_addr, a1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        mem_req, mem_ack, trap_pulse, busy, c1;
	logic [33:0] mq[$], bq[$], rq[$];
	int          errors = 0, samples_checked = 0, i;

	eau_top DUT (.*);
	eau_mem_model mem (.*);
	always #2 aclk = ~aclk;

	task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// One register access; a channel is released only at the edge that takes it
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
		logic ta, tw, done;
		int   k;
		if (w)
			bq.push_back(e);
		else
			rq.push_back(e);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
		{s_axi_arvalid, s_axi_rready} <= {2{!w}};
		done = 1'b0;
		for (k = 0; k < 200 && !done; k++) begin
			@(negedge aclk);
			ta = (s_axi_awvalid && s_axi_awready) || (s_axi_arvalid && s_axi_arready);
			tw = s_axi_wvalid && s_axi_wready;
			done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
			@(posedge aclk);
			if (ta)
				{s_axi_awvalid, s_axi_arvalid} <= 2'h0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		{s_axi_bready, s_axi_rready} <= 2'h0;
		if (!done) begin
			errors++;
			conclude();
		end
	endtask : bus

	// Bounded wait: 0 trap pulse, 1 endless chain running, 2 idle
	task automatic wait_for(input int sel);
		int k;
		for (k = 0; k < 2000 && !(sel == 0 ? trap_pulse === 1'b1 : sel == 1 ? mem_addr === 16'h2 : busy === 1'b0); k++)
			@(posedge aclk);
		if (k == 2000) begin
			errors++;
			conclude();
		end
	endtask : wait_for

	function automatic logic [31:0] ins(input logic [15:0] a, input logic n, input logic [2:0] x, input logic [3:0] op,
		input logic s, input logic [1:0] md, input logic [2:0] c);
		return {a, n, x, op, s, md, 1'b0, c, 1'b0};
	endfunction : ins

	// Observed reads and answers against the oldest note
	always @(posedge aclk) begin
		if (mem_req && mem_ack && mq.size() > 0)
			chk({18'h0, mem_addr}, mq.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			chk({s_axi_bresp, 32'h0}, bq.pop_front());
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
	end

	// Program: indexed load, double indirect add, immediate with save, index class, trap, endless chain
	initial begin
		void'($urandom(32'h675f));
		for (i = 0; i < 256; i++)
			mem.m[i] = 32'h0002_8000;
		mem.m[8'h40] = ins(16'h0010, 1'b0, 3'd2, OP_CA, 1'b0, MODE_LEFT, CLS_FIX);
		mem.m[8'h41] = ins(16'h0020, 1'b1, 3'd0, OP_AD, 1'b0, MODE_RIGHT, CLS_FIX);
		mem.m[8'h20] = ins(16'h0030, 1'b1, 3'd3, 4'h0, 1'b0, 2'h0, 3'h0);
		mem.m[8'h35] = ins(16'h0050, 1'b0, 3'd0, 4'h0, 1'b0, 2'h0, 3'h0);
		mem.m[8'h42] = ins(16'h7777, 1'b0, 3'd0, OP_CA, 1'b1, MODE_IMM, CLS_FIX);
		mem.m[8'h43] = ins(16'h0060, 1'b0, 3'd2, OP_CP, 1'b0, MODE_LEFT, CLS_IDX);
		mem.m[8'h44] = ins(16'h0070, 1'b0, 3'd0, OP_MP, 1'b0, MODE_LEFT, CLS_EXT);
		// Immediate divide by zero: overflow flag, accumulator kept
		mem.m[8'h45] = ins(16'h0000, 1'b0, 3'd0, OP_DV, 1'b0, MODE_IMM, CLS_FIX);
		mem.m[8'h0d] = $urandom;
		mem.m[8'h50] = $urandom;
		{c1, a1} = 17'(mem.m[8'h0d][31:16]) + 17'(mem.m[8'h50][15:0]);
		mq = '{34'h40, 34'h0d, 34'h41, 34'h20, 34'h35, 34'h50, 34'h42, 34'h43, 34'h60, 34'h44, 34'h70};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		bus(1'b1, REG_LOC, 32'h40, {RESP_OKAY, 32'h0});
		bus(1'b1, REG_XBASE + 8'h08, 32'hfffd, {RESP_OKAY, 32'h0});
		bus(1'b1, REG_XBASE + 8'h0c, 32'h5, {RESP_OKAY, 32'h0});
		bus(1'b1, 8'h1c, 32'h1, {RESP_SLVERR, 32'h0});
		bus(1'b1, REG_CTRL, 32'h1, {RESP_OKAY, 32'h0});
		wait_for(0);
		chk(34'(mq.size()), 34'h0);
		wait_for(1);
		halt_pin <= 1'b1;
		wait_for(2);
		bus(1'b0, REG_ACC, 32'h0, {RESP_OKAY, 32'h7777});
		bus(1'b0, REG_SAVE, 32'h0, {RESP_OKAY, 16'h0, a1});
		bus(1'b0, REG_STATUS, 32'h0, {RESP_OKAY, 32'h10});
		bus(1'b0, REG_FLAGS, 32'h0, {RESP_OKAY, 27'h0, 1'b1, c1, 3'h2});
		// Interrupt held high: restart, every resolution must abort to idle
		halt_pin <= 1'b0;
		irq_pin  <= 1'b1;
		bus(1'b1, REG_CTRL, 32'h3, {RESP_OKAY, 32'h0});
		bus(1'b1, REG_CTRL, 32'h0, {RESP_OKAY, 32'h0});
		wait_for(2);
		bus(1'b0, REG_STATUS, 32'h0, {RESP_OKAY, 32'h10});
		bus(1'b0, 8'h1c, 32'h0, {RESP_SLVERR, 32'h0});
		chk({26'h0, trap_num}, 34'h2);
		conclude();
	end
endmodule : tb_effective_address_unit
